/* design/sbfdc_loader.sv */
// Serial boot loader with fuse locks, decryption launch and hand-over
// Summary of operation
// - A 128-bit control fuse box is held; only its low bits matter.
// - Every fuse reads clear until blown, so all locks start off.
// - Fuse bit 0 set turns on secure mode.
// - Fuse bit 1 set refuses reading both key boxes.
// - Fuse bit 2 set refuses writing both key boxes.
// - Fuse bit 5 set refuses reading the control box.
// - Fuse bit 6 set refuses writing the control box.
// - Fuse bit 7 set refuses program RAM readback.
// - Fuse bit 10 set puts vector and block count into the signature.
// - Fuse bit 16 set turns the debug port off.
// - Basic decrypt command starts decryption of program RAM.
// - Extended decrypt command verifies program, vector and count.
// - Decrypt commands ignore the frame address and data.
// - Forced fuse makes both decrypt commands cover vector and count.
// - Two password frames in order unlock the loader after reset.
// - Status answers 2 while decrypting, zero when ready.
// - Clearing cpu hold frees the CPU; hand-over gives MISO away, and the stop variant also stops the loader.
// - Every frame is answered with a 32-bit signature and state word.
// - Frame is 32-bit address, 16-bit command, then 32-bit data words.
// - Status bit 0 shows fuse blowing; all zero when nothing runs.
`timescale 1ns/1ns
module sbfdc_loader (
	// Clock and control
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clkEn,
	// Loader serial pins
	input wire logic sckPin,
	input wire logic csPin_n,
	input wire logic mosiPin,
	output logic misoOut,
	output logic misoOe,
	// Program RAM
	output sbfdc_pkg::sbfdc_ram_s ramReq,
	input wire logic [31:0] ramRdata,
	// Decryption engine
	output logic decStart,
	output logic decIvCount,
	output logic [14:0] decBlocks,
	input wire logic decBusy,
	// System state
	input wire logic [2:0] rstCause,
	output logic cpuHold,
	output logic secureMode,
	output logic debugPortOff,
	output logic misoToApp,
	output logic loaderClkOff,
	output logic unlocked
);

	typedef struct packed {
		logic sckS1, sckS2, sckD;
		logic csS1, csS2;
		logic mosiS1, mosiS2;
		sbfdc_pkg::sbfdc_frame_e fr;
		logic [4:0] segCnt;
		logic [31:0] shIn;
		logic [31:0] tx;
		logic loadNext;
		logic [31:0] nextWord;
		logic [31:0] addr;
		logic [15:0] cmd;
		logic [2:0] wordIdx;
		logic [31:0] ramPtr;
		logic passOne;
		logic open;
		logic rdPend;
		logic ramWait;
		logic [sbfdc_pkg::CTRL_LIVE_W-1:0] ctrlLive;
		logic [14:0] blockCnt;
		sbfdc_pkg::sbfdc_box_e tgt;
		sbfdc_pkg::sbfdc_copy_e cpSt;
		logic [1:0] cpIdx;
		logic [4:0] cpSrc;
		logic [4:0] cpDst;
		logic cpOr, cpWrEn, cpCtrl;
		logic [31:0] cpTmp;
		logic [15:0] fuseCnt;
		logic cpuHold, toApp, clkOff, decStart, decIv;
		sbfdc_pkg::sbfdc_ram_s ram;
	} sbfdc_loader_s;

	sbfdc_loader_s s;
	sbfdc_loader_s next_s;
	sbfdc_pkg::sbfdc_mem_s memReq;
	logic [31:0] memRdata;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [4:0] boxBase(input sbfdc_pkg::sbfdc_box_e b);
		logic [4:0] r;
		r = sbfdc_pkg::MI_CTRL;
		if (b == sbfdc_pkg::BOX_ENC) begin
			r = sbfdc_pkg::MI_KENC;
		end else if (b == sbfdc_pkg::BOX_TAG) begin
			r = sbfdc_pkg::MI_KTAG;
		end
		return r;
	endfunction

	function automatic logic [4:0] wordAt(input logic [4:0] base, input logic [2:0] idx);
		return base + {3'h0, idx[1:0]};
	endfunction

	sbfdc_word_mem #(
		.W(sbfdc_pkg::WORD_W),
		.DEPTH(sbfdc_pkg::MEM_DEPTH)
	) u_store (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clkEn(clkEn & ~s.clkOff),
		.req(memReq),
		.rdata(memRdata)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign misoOut = s.tx[31];
	assign misoOe = ~s.csS2 & ~s.toApp;
	assign ramReq = s.ram;
	assign decStart = s.decStart;
	assign decIvCount = s.decIv;
	assign decBlocks = s.blockCnt;
	assign cpuHold = s.cpuHold;
	assign secureMode = s.ctrlLive[sbfdc_pkg::FB_SECURE];
	assign debugPortOff = s.ctrlLive[sbfdc_pkg::FB_DBG_OFF];
	assign misoToApp = s.toApp;
	assign loaderClkOff = s.clkOff;
	assign unlocked = s.open;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic sckRise, sckFall, segEnd, readTurn, fromCmd, wrOk;
		logic [31:0] word, ptr, sigWord, status;
		next_s = s;
		memReq = '0;
		sckRise = s.sckS2 & ~s.sckD;
		sckFall = ~s.sckS2 & s.sckD;
		word = {s.shIn[30:0], s.mosiS2};
		segEnd = 1'b0;
		readTurn = 1'b0;
		fromCmd = (s.fr == sbfdc_pkg::FR_CMD);
		ptr = fromCmd ? s.addr : s.ramPtr + sbfdc_pkg::WORD_STEP;
		wrOk = (s.wordIdx < 3'h4);
		sigWord = {sbfdc_pkg::BOOT_SIGN, rstCause, 14'h0000};
		status = sbfdc_pkg::STAT_IDLE;
		status[sbfdc_pkg::STAT_DEC_BIT] = decBusy | s.decStart;
		status[sbfdc_pkg::STAT_FUSE_BIT] = (s.fuseCnt != 16'h0000);
		next_s.sckS1 = sckPin;
		next_s.sckS2 = s.sckS1;
		next_s.sckD = s.sckS2;
		next_s.csS1 = csPin_n;
		next_s.csS2 = s.csS1;
		next_s.mosiS1 = mosiPin;
		next_s.mosiS2 = s.mosiS1;
		next_s.decStart = 1'b0;
		next_s.ram.we = 1'b0;
		next_s.ram.re = 1'b0;
		next_s.ramWait = s.ram.re;
		next_s.rdPend = 1'b0;
		if (s.rdPend) begin
			next_s.nextWord = memRdata;
		end
		if (s.ramWait) begin
			next_s.nextWord = ramRdata;
		end
		if (s.fuseCnt != 16'h0000) begin
			next_s.fuseCnt = s.fuseCnt - 16'h0001;
		end

		// Copy engine between word store areas
		case (s.cpSt)
			sbfdc_pkg::CP_RSRC: begin
				memReq.re = 1'b1;
				memReq.addr = s.cpSrc + {3'h0, s.cpIdx};
				next_s.cpSt = sbfdc_pkg::CP_RDST;
			end
			sbfdc_pkg::CP_RDST: begin
				next_s.cpTmp = memRdata;
				memReq.re = 1'b1;
				memReq.addr = s.cpDst + {3'h0, s.cpIdx};
				next_s.cpSt = sbfdc_pkg::CP_WR;
			end
			sbfdc_pkg::CP_WR: begin
				memReq.we = s.cpWrEn;
				memReq.addr = s.cpDst + {3'h0, s.cpIdx};
				// fuse bits only ever blow on
				memReq.wdata = s.cpOr ? (s.cpTmp | memRdata) : s.cpTmp;
				if (s.cpCtrl && s.cpIdx == 2'h0) begin
					next_s.ctrlLive = s.cpTmp[sbfdc_pkg::CTRL_LIVE_W-1:0];
				end
				next_s.cpIdx = s.cpIdx + 2'h1;
				next_s.cpSt = (s.cpIdx == 2'h3) ? sbfdc_pkg::CP_IDLE : sbfdc_pkg::CP_RSRC;
			end
			default: begin
				next_s.cpIdx = 2'h0;
			end
		endcase

		// Frame receive and answer
		if (s.csS2) begin
			next_s.fr = sbfdc_pkg::FR_IDLE;
			next_s.segCnt = 5'h00;
			next_s.loadNext = 1'b0;
			next_s.tx = sigWord;
		end else if (sckRise) begin
			next_s.shIn = word;
			next_s.segCnt = s.segCnt + 5'h01;
			case (s.fr)
				sbfdc_pkg::FR_IDLE, sbfdc_pkg::FR_ADDR: begin
					next_s.fr = sbfdc_pkg::FR_ADDR;
					if (s.segCnt == sbfdc_pkg::ADDR_LAST) begin
						next_s.addr = word;
						next_s.fr = sbfdc_pkg::FR_CMD;
						segEnd = 1'b1;
					end
				end
				sbfdc_pkg::FR_CMD: begin
					if (s.segCnt == sbfdc_pkg::CMD_LAST) begin
						next_s.cmd = word[15:0];
						next_s.fr = sbfdc_pkg::FR_DATA;
						next_s.wordIdx = 3'h0;
						segEnd = 1'b1;
						readTurn = 1'b1;
					end
				end
				default: begin
					if (s.segCnt == sbfdc_pkg::DATA_LAST) begin
						segEnd = 1'b1;
						readTurn = 1'b1;
						if (s.wordIdx != 3'h7) begin
							next_s.wordIdx = s.wordIdx + 3'h1;
						end
						if (!s.open) begin
							if (s.cmd == sbfdc_pkg::CMD_UNLOCK) begin
								next_s.passOne = (word == sbfdc_pkg::PASS_FIRST);
								next_s.open = s.passOne && (word == sbfdc_pkg::PASS_SECOND);
							end
						end else if (s.cmd == sbfdc_pkg::CMD_WR_MULTI) begin
							next_s.ram.we = 1'b1;
							next_s.ram.addr = s.ramPtr;
							next_s.ram.wdata = word;
							next_s.ramPtr = s.ramPtr + sbfdc_pkg::WORD_STEP;
						end else if (s.cmd == sbfdc_pkg::CMD_SET_IV && wrOk) begin
							memReq.we = 1'b1;
							memReq.addr = wordAt(sbfdc_pkg::MI_IV, s.wordIdx);
							memReq.wdata = word;
						end else if (s.cmd == sbfdc_pkg::CMD_SET_SIG && wrOk) begin
							memReq.we = 1'b1;
							memReq.addr = wordAt(sbfdc_pkg::MI_SIG, s.wordIdx);
							memReq.wdata = word;
						end else if (s.cmd == sbfdc_pkg::CMD_BUF_WR && wrOk) begin
							memReq.we = 1'b1;
							memReq.addr = wordAt(sbfdc_pkg::MI_BUF, s.wordIdx);
							memReq.wdata = word;
						end else if (s.wordIdx == 3'h0 && s.cpSt == sbfdc_pkg::CP_IDLE) begin
							next_s.cpIdx = 2'h0;
							next_s.cpOr = 1'b0;
							next_s.cpWrEn = 1'b1;
							next_s.cpCtrl = 1'b0;
							case (s.cmd)
								sbfdc_pkg::CMD_WR_ONE: begin
									if (s.addr == sbfdc_pkg::CPU_HOLD_ADDR) begin
										next_s.cpuHold = word[sbfdc_pkg::CPU_HOLD_BIT];
									end else begin
										next_s.ram.we = 1'b1;
										next_s.ram.addr = s.addr;
										next_s.ram.wdata = word;
									end
								end
								sbfdc_pkg::CMD_SET_COUNT: begin
									next_s.blockCnt = word[14:0];
								end
								sbfdc_pkg::CMD_BUF_ENC, sbfdc_pkg::CMD_BUF_TAG: begin
									if (!s.ctrlLive[sbfdc_pkg::FB_WR_KEY]) begin
										next_s.cpSrc = sbfdc_pkg::MI_BUF;
										next_s.cpDst = sbfdc_pkg::MI_TAMP;
										next_s.cpSt = sbfdc_pkg::CP_RSRC;
										next_s.tgt = (s.cmd == sbfdc_pkg::CMD_BUF_ENC) ?
											sbfdc_pkg::BOX_ENC : sbfdc_pkg::BOX_TAG;
									end
								end
								sbfdc_pkg::CMD_BUF_CTRL: begin
									if (!s.ctrlLive[sbfdc_pkg::FB_WR_CTRL]) begin
										next_s.cpSrc = sbfdc_pkg::MI_BUF;
										next_s.cpDst = sbfdc_pkg::MI_TAMP;
										next_s.cpSt = sbfdc_pkg::CP_RSRC;
										next_s.tgt = sbfdc_pkg::BOX_CTRL;
									end
								end
								sbfdc_pkg::CMD_BLOW: begin
									if (s.tgt != sbfdc_pkg::BOX_NONE && s.fuseCnt == 16'h0000) begin
										next_s.cpSrc = sbfdc_pkg::MI_TAMP;
										next_s.cpDst = boxBase(s.tgt);
										next_s.cpOr = 1'b1;
										next_s.cpSt = sbfdc_pkg::CP_RSRC;
										next_s.tgt = sbfdc_pkg::BOX_NONE;
										next_s.fuseCnt = sbfdc_pkg::FUSE_BLOW_CYC;
									end
								end
								sbfdc_pkg::CMD_GET_ENC, sbfdc_pkg::CMD_GET_TAG: begin
									if (!s.ctrlLive[sbfdc_pkg::FB_RD_KEY]) begin
										next_s.cpSrc = (s.cmd == sbfdc_pkg::CMD_GET_ENC) ?
											sbfdc_pkg::MI_KENC : sbfdc_pkg::MI_KTAG;
										next_s.cpDst = sbfdc_pkg::MI_TAMP;
										next_s.cpSt = sbfdc_pkg::CP_RSRC;
									end
								end
								sbfdc_pkg::CMD_GET_CTRL: begin
									next_s.cpWrEn = ~s.ctrlLive[sbfdc_pkg::FB_RD_CTRL];
									next_s.cpCtrl = 1'b1;
									next_s.cpSrc = sbfdc_pkg::MI_CTRL;
									next_s.cpDst = sbfdc_pkg::MI_TAMP;
									next_s.cpSt = sbfdc_pkg::CP_RSRC;
								end
								sbfdc_pkg::CMD_DECRYPT, sbfdc_pkg::CMD_DECRYPT_EXT: begin
									next_s.decStart = 1'b1;
									next_s.decIv = (s.cmd == sbfdc_pkg::CMD_DECRYPT_EXT) |
										s.ctrlLive[sbfdc_pkg::FB_FORCE_IV];
								end
								sbfdc_pkg::CMD_HAND_MISO: begin
									next_s.toApp = 1'b1;
								end
								sbfdc_pkg::CMD_HAND_STOP: begin
									next_s.toApp = 1'b1;
									next_s.clkOff = 1'b1;
								end
								default: begin
									next_s.cpWrEn = 1'b1;
								end
							endcase
						end
					end
				end
			endcase
			// Prepare the next answer word
			if (segEnd) begin
				next_s.segCnt = 5'h00;
				next_s.loadNext = 1'b1;
				next_s.nextWord = 32'h00000000;
			end
			if (readTurn && s.open) begin
				if (s.cmd == sbfdc_pkg::CMD_STATUS || (fromCmd && word[15:0] == sbfdc_pkg::CMD_STATUS)) begin
					next_s.nextWord = status;
				end
				if (fromCmd) begin
					next_s.ramPtr = s.addr;
				end
				if (!s.ctrlLive[sbfdc_pkg::FB_RD_RAM] && ((fromCmd &&
					(word[15:0] == sbfdc_pkg::CMD_RD_MULTI || word[15:0] == sbfdc_pkg::CMD_RD_ONE))
					|| (!fromCmd && s.cmd == sbfdc_pkg::CMD_RD_MULTI))) begin
					next_s.ram.re = 1'b1;
					next_s.ram.addr = ptr;
					next_s.ramPtr = ptr;
				end
				if (s.cpSt == sbfdc_pkg::CP_IDLE && ((fromCmd && word[15:0] == sbfdc_pkg::CMD_TAMP_RD)
					|| (!fromCmd && s.cmd == sbfdc_pkg::CMD_TAMP_RD && s.wordIdx < 3'h3))) begin
					memReq.re = 1'b1;
					memReq.addr = fromCmd ? sbfdc_pkg::MI_TAMP :
						wordAt(sbfdc_pkg::MI_TAMP, s.wordIdx + 3'h1);
					next_s.rdPend = 1'b1;
				end
			end
		end else if (sckFall) begin
			next_s.tx = s.loadNext ? s.nextWord : {s.tx[30:0], 1'b0};
			next_s.loadNext = 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s <= '0;
			s.sckS1 <= 1'b0;
			s.csS1 <= 1'b1;
			s.csS2 <= 1'b1;
			s.ctrlLive <= sbfdc_pkg::CTRL_RESET;
			s.fr <= sbfdc_pkg::FR_IDLE;
			s.cpSt <= sbfdc_pkg::CP_IDLE;
			s.tgt <= sbfdc_pkg::BOX_NONE;
			s.cpuHold <= 1'b1;
		end else if (clkEn && !s.clkOff) begin
			s <= next_s;
		end
	end

endmodule // sbfdc_loader

/* design/sbfdc_pkg.sv */
// Shared constants and types for the secure boot loader
package sbfdc_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int WORD_W = 32;
	localparam int FUSE_BITS = 128;
	localparam logic [4:0] ADDR_LAST = 5'h1F;
	localparam logic [4:0] CMD_LAST = 5'h0F;
	localparam logic [4:0] DATA_LAST = 5'h1F;

	// ****************************************
	// Commands
	// ****************************************
	localparam logic [15:0] CMD_WR_ONE = 16'h0000;
	localparam logic [15:0] CMD_WR_MULTI = 16'h0001;
	localparam logic [15:0] CMD_RD_MULTI = 16'h0002;
	localparam logic [15:0] CMD_RD_ONE = 16'h0003;
	localparam logic [15:0] CMD_SET_COUNT = 16'h0004;
	localparam logic [15:0] CMD_SET_IV = 16'h0005;
	localparam logic [15:0] CMD_SET_SIG = 16'h0006;
	localparam logic [15:0] CMD_BUF_WR = 16'h0007;
	localparam logic [15:0] CMD_BUF_ENC = 16'h0008;
	localparam logic [15:0] CMD_BUF_TAG = 16'h0009;
	localparam logic [15:0] CMD_BUF_CTRL = 16'h000B;
	localparam logic [15:0] CMD_BLOW = 16'h000C;
	localparam logic [15:0] CMD_GET_ENC = 16'h000D;
	localparam logic [15:0] CMD_GET_TAG = 16'h000E;
	localparam logic [15:0] CMD_GET_CTRL = 16'h0010;
	localparam logic [15:0] CMD_TAMP_RD = 16'h0011;
	localparam logic [15:0] CMD_STATUS = 16'h0012;
	localparam logic [15:0] CMD_DECRYPT = 16'h0013;
	localparam logic [15:0] CMD_DECRYPT_EXT = 16'h0015;
	localparam logic [15:0] CMD_HAND_MISO = 16'hA55A;
	localparam logic [15:0] CMD_HAND_STOP = 16'hA66A;
	localparam logic [15:0] CMD_UNLOCK = 16'hDE05;
	localparam logic [31:0] PASS_FIRST = 32'h5345ACBA;
	localparam logic [31:0] PASS_SECOND = 32'hACBA5345;

	// ****************************************
	// Control fuse positions
	// ****************************************
	localparam int CTRL_LIVE_W = 18;
	localparam int FB_SECURE = 0;
	localparam int FB_RD_KEY = 1;
	localparam int FB_WR_KEY = 2;
	localparam int FB_RD_CTRL = 5;
	localparam int FB_WR_CTRL = 6;
	localparam int FB_RD_RAM = 7;
	localparam int FB_FORCE_IV = 10;
	localparam int FB_DBG_OFF = 16;
	localparam logic [CTRL_LIVE_W-1:0] CTRL_RESET = 18'h00000;

	// ****************************************
	// Answer words and system addresses
	// ****************************************
	localparam logic [14:0] BOOT_SIGN = 15'h2B1A;
	localparam logic [31:0] STAT_IDLE = 32'h00000000;
	localparam int STAT_FUSE_BIT = 0;
	localparam int STAT_DEC_BIT = 1;
	localparam logic [31:0] CPU_HOLD_ADDR = 32'h400E1800;
	localparam int CPU_HOLD_BIT = 0;
	localparam logic [31:0] WORD_STEP = 32'h00000004;

	// ****************************************
	// Word store map
	// ****************************************
	localparam int MEM_DEPTH = 32;
	localparam int MEM_AW = 5;
	localparam logic [4:0] MI_BUF = 5'h00;
	localparam logic [4:0] MI_TAMP = 5'h04;
	localparam logic [4:0] MI_IV = 5'h08;
	localparam logic [4:0] MI_SIG = 5'h0C;
	localparam logic [4:0] MI_KENC = 5'h10;
	localparam logic [4:0] MI_KTAG = 5'h14;
	localparam logic [4:0] MI_CTRL = 5'h18;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 10;
	localparam int FUSE_BLOW_NS = 1000;
	localparam logic [15:0] FUSE_BLOW_CYC = 16'((FUSE_BLOW_NS + CLK_NS - 1) / CLK_NS);

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		FR_IDLE = 2'h0,
		FR_ADDR = 2'h1,
		FR_CMD = 2'h3,
		FR_DATA = 2'h2
	} sbfdc_frame_e;

	typedef enum logic [1:0] {
		CP_IDLE = 2'h0,
		CP_RSRC = 2'h1,
		CP_RDST = 2'h3,
		CP_WR = 2'h2
	} sbfdc_copy_e;

	typedef enum logic [1:0] {
		BOX_ENC = 2'h0,
		BOX_TAG = 2'h1,
		BOX_CTRL = 2'h2,
		BOX_NONE = 2'h3
	} sbfdc_box_e;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} sbfdc_ram_s;

	typedef struct packed {
		logic [4:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} sbfdc_mem_s;

endpackage

/* design/sbfdc_word_mem.sv */
// Word store for buffer, holding, vector, signature and fuse boxes
`timescale 1ns/1ns
module sbfdc_word_mem #(
	parameter int W = 32,
	parameter int DEPTH = 32
) (
	// Clock and control
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clkEn,
	// Access port
	input sbfdc_pkg::sbfdc_mem_s req,
	output logic [W-1:0] rdata
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] words;
		logic [W-1:0] rd;
	} sbfdc_mem_state_s;

	sbfdc_mem_state_s s;
	sbfdc_mem_state_s next_s;

	assign rdata = s.rd;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s = s;
		if (req.re) begin
			next_s.rd = s.words[req.addr];
		end
		if (req.we) begin
			next_s.words[req.addr] = req.wdata;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s <= '0;
		end else if (clkEn) begin
			s <= next_s;
		end
	end

endmodule // sbfdc_word_mem

/* testbench/sbfdc_host.sv */
// Host serial master model that sends loader frames
`timescale 1ns/1ns
module sbfdc_host (
	// Serial pins
	output logic sck,
	output logic csN,
	output logic mosi,
	input wire logic miso
);
	// ****************************************
	// Frame transfer
	// ****************************************
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
	end
	task automatic frame(input logic [31:0] a, input logic [15:0] c, input logic [63:0] d,
		input int n, output logic [31:0] sg, output logic [63:0] rd);
		logic [111:0] tx;
		int nb;
		tx = {a, c, d};
		nb = 48 + 32 * n;
		rd = 64'h0;
		csN = 1'b0;
		#80;
		for (int i = 0; i < nb; i++) begin
			mosi = tx[111 - i];
			#80 sck = 1'b1;
			if (i < 32)
				sg[31 - i] = miso;
			else if (i >= 48)
				rd[111 - i] = miso;
			#80 sck = 1'b0;
		end
		#80 csN = 1'b1;
		mosi = ~mosi;
		#400;
	endtask
endmodule // sbfdc_host

/* testbench/sbfdc_loader_props.sv */
// Port checker for the serial boot loader
`timescale 1ns/1ns
module sbfdc_loader_props (
	// Clock and control
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clkEn,
	// Serial pins
	input wire logic sckPin,
	input wire logic csPin_n,
	input wire logic mosiPin,
	input wire logic misoOut,
	input wire logic misoOe,
	// Program RAM
	input sbfdc_pkg::sbfdc_ram_s ramReq,
	input wire logic [31:0] ramRdata,
	// Decryption
	input wire logic decStart,
	input wire logic decIvCount,
	input wire logic [14:0] decBlocks,
	input wire logic decBusy,
	// System state
	input wire logic [2:0] rstCause,
	input wire logic cpuHold,
	input wire logic secureMode,
	input wire logic debugPortOff,
	input wire logic misoToApp,
	input wire logic loaderClkOff,
	input wire logic unlocked
);
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	sequence s_clk_stop;
		$rose(loaderClkOff);
	endsequence
	a_reset_state: assert property (@(posedge ref_clk) disable iff (1'b0)
		!rstn && clkEn |=> cpuHold && !unlocked && !decStart && !misoToApp)
		else $error("reset state wrong");
	a_locked_quiet: assert property (!unlocked |-> !decStart && !ramReq.we && !ramReq.re)
		else $error("locked loader acted");
	a_start_pulse: assert property (decStart |=> !decStart)
		else $error("start not one cycle");
	a_secure_unlock: assert property ($rose(secureMode) |-> unlocked)
		else $error("secure mode while locked");
	a_debug_unlock: assert property ($rose(debugPortOff) |-> unlocked)
		else $error("debug off while locked");
	a_cpu_release: assert property ($fell(cpuHold) |-> unlocked)
		else $error("cpu released while locked");
	a_stop_handover: assert property (s_clk_stop |-> misoToApp)
		else $error("clock off without handover");
	a_clk_frozen: assert property (loaderClkOff |=> loaderClkOff && $stable(ramReq) && !decStart)
		else $error("loader active after stop");
	a_oe_handover: assert property (misoToApp |-> !misoOe)
		else $error("loader drives after handover");
	a_oe_idle: assert property (csPin_n [*4] |-> !misoOe)
		else $error("output enabled without select");
endmodule // sbfdc_loader_props

bind sbfdc_loader sbfdc_loader_props u_sbfdc_loader_props (
	.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .sckPin(sckPin), .csPin_n(csPin_n),
	.mosiPin(mosiPin), .misoOut(misoOut), .misoOe(misoOe), .ramReq(ramReq),
	.ramRdata(ramRdata), .decStart(decStart), .decIvCount(decIvCount),
	.decBlocks(decBlocks), .decBusy(decBusy), .rstCause(rstCause), .cpuHold(cpuHold),
	.secureMode(secureMode), .debugPortOff(debugPortOff), .misoToApp(misoToApp),
	.loaderClkOff(loaderClkOff), .unlocked(unlocked));

/* testbench/sbfdc_loader_tb.sv */
// Self-checking bench for the serial boot loader
`timescale 1ns/1ns
module sbfdc_loader_tb;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic clkEn = 1'b1;
	logic [2:0] rstCause = 3'h5;
	logic [31:0] ramRdata = 32'h0;
	logic [15:0] busyCnt = 16'h0;
	wire logic decBusy;
	wire logic sckW;
	wire logic csW;
	wire logic mosiW;
	wire logic misoW;
	logic misoOut, misoOe, decStart, decIvCount, cpuHold, secureMode, debugPortOff;
	logic misoToApp, loaderClkOff, unlocked;
	logic [14:0] decBlocks;
	sbfdc_pkg::sbfdc_ram_s ramReq;
	logic [31:0] mem [0:7];
	logic [31:0] sg;
	logic [63:0] rd;
	int starts = 0;
	int cycles = 0;
	int num_errors = 0;
	int comparisons = 0;
	always #5 ref_clk = ~ref_clk;
	assign misoW = misoOe ? misoOut : ref_clk;
	assign decBusy = busyCnt != 16'h0;
	sbfdc_host u_sbfdc_host (.sck(sckW), .csN(csW), .mosi(mosiW), .miso(misoW));
	sbfdc_loader u_sbfdc_loader (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn),
		.sckPin(sckW), .csPin_n(csW), .mosiPin(mosiW), .misoOut(misoOut), .misoOe(misoOe),
		.ramReq(ramReq), .ramRdata(ramRdata), .decStart(decStart), .decIvCount(decIvCount),
		.decBlocks(decBlocks), .decBusy(decBusy), .rstCause(rstCause), .cpuHold(cpuHold),
		.secureMode(secureMode), .debugPortOff(debugPortOff), .misoToApp(misoToApp),
		.loaderClkOff(loaderClkOff), .unlocked(unlocked));
	// ****************************************
	// RAM, decrypt engine and timeout
	// ****************************************
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		ramRdata <= mem[ramReq.addr[4:2]];
		if (ramReq.we)
			mem[ramReq.addr[4:2]] <= ramReq.wdata;
		if (decStart) begin
			busyCnt <= 16'd3000;
			starts <= starts + 1;
		end else if (busyCnt != 16'h0)
			busyCnt <= busyCnt - 16'h1;
		if (cycles == 80000) begin
			num_errors++;
			results();
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic fr(input logic [31:0] a, input logic [15:0] c, input logic [63:0] d,
		input int n);
		u_sbfdc_host.frame(a, c, d, n, sg, rd);
		check(sg, {sbfdc_pkg::BOOT_SIGN, rstCause, 14'h0});
	endtask
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		check(32'({cpuHold, unlocked, secureMode, debugPortOff}), 32'h8);
		fr(32'h0, sbfdc_pkg::CMD_STATUS, 64'h0, 1);
		check(rd[63:32], 32'h0);
		fr(32'h0, sbfdc_pkg::CMD_DECRYPT, 64'h0, 1);
		check(32'(starts), 32'h0);
		fr(32'h0, sbfdc_pkg::CMD_UNLOCK, {sbfdc_pkg::PASS_SECOND, 32'h0}, 1);
		fr(32'h0, sbfdc_pkg::CMD_UNLOCK, {sbfdc_pkg::PASS_FIRST, 32'h0}, 1);
		check(32'(unlocked), 32'h0);
		fr(32'h0, sbfdc_pkg::CMD_UNLOCK, {sbfdc_pkg::PASS_SECOND, 32'h0}, 1);
		check(32'(unlocked), 32'h1);
		fr(32'h0, sbfdc_pkg::CMD_WR_MULTI, 64'h11111111_22222222, 2);
		check(mem[0], 32'h11111111);
		check(mem[1], 32'h22222222);
		fr(32'h0, sbfdc_pkg::CMD_RD_MULTI, 64'h0, 2);
		check(rd[63:32], 32'h11111111);
		check(rd[31:0], 32'h22222222);
		fr(32'hFFFF, sbfdc_pkg::CMD_SET_COUNT, 64'h0001ABCD_00000000, 1);
		check(32'(decBlocks), 32'h2BCD);
		fr(32'h1234, sbfdc_pkg::CMD_DECRYPT, 64'hDEADBEEF_00000000, 1);
		check(32'(starts), 32'h1);
		check(32'(decIvCount), 32'h0);
		fr(32'h0, sbfdc_pkg::CMD_STATUS, 64'h0, 1);
		check(rd[63:32], 32'h2);
		repeat (3200) @(posedge ref_clk);
		fr(32'h0, sbfdc_pkg::CMD_STATUS, 64'h0, 1);
		check(rd[63:32], 32'h0);
		fr(32'h0, sbfdc_pkg::CMD_DECRYPT_EXT, 64'h0, 1);
		check(32'(decIvCount), 32'h1);
		repeat (3200) @(posedge ref_clk);
		fr(32'h0, sbfdc_pkg::CMD_BUF_WR, 64'h00010481_00000000, 1);
		fr(32'h0, sbfdc_pkg::CMD_BUF_CTRL, 64'h0, 1);
		fr(32'h0, sbfdc_pkg::CMD_BLOW, 64'h0, 1);
		fr(32'h0, sbfdc_pkg::CMD_STATUS, 64'h0, 1);
		check(rd[63:32], 32'h0);
		check(32'(secureMode), 32'h0);
		fr(32'h0, sbfdc_pkg::CMD_GET_CTRL, 64'h0, 1);
		check(32'({secureMode, debugPortOff}), 32'h3);
		fr(32'h0, sbfdc_pkg::CMD_DECRYPT, 64'h0, 1);
		check(32'(decIvCount), 32'h1);
		repeat (3200) @(posedge ref_clk);
		fr(32'h0, sbfdc_pkg::CMD_RD_MULTI, 64'h0, 1);
		check(rd[63:32], 32'h0);
		fr(sbfdc_pkg::CPU_HOLD_ADDR, sbfdc_pkg::CMD_WR_ONE, 64'h0, 1);
		check(32'(cpuHold), 32'h0);
		fr(32'h0, sbfdc_pkg::CMD_HAND_STOP, 64'h0, 1);
		check(32'({misoToApp, loaderClkOff, misoOe}), 32'h6);
		results();
	end
endmodule // sbfdc_loader_tb
